// ===== hpp_defs.vh
// Constants for the host parallel slave port
`ifndef HPP_DEFS_VH
`define HPP_DEFS_VH
`define HPP_DATA_W 8
`define HPP_SYNC_STAGES 2
`define HPP_MODE_COMM 1'h0
`define HPP_MODE_FAST 1'h1
`define HPP_TYPE_DATA 1'h0
`define HPP_TYPE_AUX 1'h1
`define HPP_KIND_DATA 2'h0
`define HPP_KIND_AUX 2'h1
`define HPP_KIND_FAST 2'h2
`define HPP_STATUS_RST 8'h00
`define HPP_CTRL_RST 8'h00
`define HPP_PIPE_RST 8'h00
`endif

// ===== hpp_sync.v
// Two-stage synchroniser for the host strobes
`timescale 1ns/1ps
module hpp_sync (
  input wire sys_clk,
  input wire sys_rst,
  input wire clk_en,
  input wire [2:0] async_in,
  output wire [2:0] sync_out
);
  reg [2:0] meta_r;
  reg [2:0] stable_r;

  ////////////////////////////////////////////////////////////////
  // Strobes idle high, so reset to the inactive level
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      meta_r <= 3'h7;
      stable_r <= 3'h7;
    end else if (clk_en) begin
      meta_r <= async_in;
      stable_r <= meta_r;
    end
  end

  assign sync_out = stable_r;
endmodule // hpp_sync

// ===== hpp_port.v
// Host parallel slave port: strobe decode, data capture and read drive
`timescale 1ns/1ps
`include "hpp_defs.vh"
module hpp_port (
  input wire sys_clk,
  input wire sys_rst,
  input wire clk_en,
  input wire host_select_n,
  input wire host_read_n,
  input wire host_write_n,
  input wire transfer_type_sel,
  input wire port_mode_sel,
  input wire [7:0] host_data_low_in,
  output wire [7:0] host_data_low_out,
  output wire host_data_low_oe,
  input wire [7:0] host_data_high_in,
  output wire [7:0] host_data_high_out,
  output wire host_data_high_oe,
  output wire host_data_irq,
  output wire transfer_ready_flag,
  // Device side: data for the host
  input wire [7:0] dev_rd_data,
  input wire [7:0] dev_rd_data_high,
  input wire [7:0] dev_status,
  input wire dev_rd_valid,
  output wire dev_rd_taken,
  // Device side: data from the host
  output reg [7:0] dev_wr_data,
  output reg [7:0] dev_wr_data_high,
  output reg [1:0] dev_wr_kind,
  output reg dev_wr_strobe,
  input wire dev_fast_done
);
  wire [2:0] strb_sync;
  wire sel_s;
  wire rd_s;
  wire wr_s;
  reg rd_d_r;
  reg wr_d_r;
  reg irq_r;
  reg rdy_r;
  reg [7:0] out_low_r;
  reg [7:0] out_high_r;
  reg [7:0] lat_low_r;
  reg [7:0] lat_high_r;
  reg [1:0] lat_kind_r;
  wire rd_start;
  wire rd_end;
  wire wr_end;
  // Pin copies delayed to line up with the synchronised strobes
  reg [7:0] low_p1_r;
  reg [7:0] low_p2_r;
  reg [7:0] high_p1_r;
  reg [7:0] high_p2_r;
  reg [1:0] mode_pipe_r;
  reg [1:0] tsel_pipe_r;
  wire mode_dly;
  wire tsel_dly;
  wire wr_start;

  // Kind of item from the address pins
  function [1:0] kind_of;
    input mode;
    input tsel;
    begin
      if (mode == `HPP_MODE_FAST)
        kind_of = `HPP_KIND_FAST;
      else if (tsel == `HPP_TYPE_AUX)
        kind_of = `HPP_KIND_AUX;
      else
        kind_of = `HPP_KIND_DATA;
    end
  endfunction

  // Rising edge of a synchronised level; invert both for a falling edge
  function edge_of;
    input now_lvl;
    input was_lvl;
    begin
      edge_of = now_lvl & ~was_lvl;
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  // Strobes carry no clock, so they go through a synchroniser.
  // Limitation: a strobe held low for under one clock cycle may be
  // missed altogether, so hosts must stretch their strobes.
  hpp_sync u_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .async_in({host_select_n, host_read_n, host_write_n}),
    .sync_out(strb_sync)
  );

  assign sel_s = ~strb_sync[2];
  assign rd_s = sel_s & ~strb_sync[1];
  assign wr_s = sel_s & ~strb_sync[0];
  // Edges only from synchronised copies
  assign rd_start = edge_of(rd_s, rd_d_r);
  assign rd_end = edge_of(~rd_s, ~rd_d_r);
  assign wr_start = edge_of(wr_s, wr_d_r);
  // Write ends when the synchronised write pin rises while still selected
  assign wr_end = ~strb_sync[0] ? 1'h0 : (wr_d_r & sel_s);
  // Address pins as they stood when the synchronised strobes were sampled
  assign mode_dly = mode_pipe_r[1];
  assign tsel_dly = tsel_pipe_r[1];
  assign dev_rd_taken = rd_end;

  ////////////////////////////////////////////////////////////////
  // Raw pin decode drives the bus at once; sync adds no turn-on delay
  assign host_data_low_oe = ~host_select_n & ~host_read_n;
  assign host_data_high_oe = host_data_low_oe & (port_mode_sel == `HPP_MODE_FAST);
  assign host_data_low_out = out_low_r;
  assign host_data_high_out = out_high_r;
  assign host_data_irq = irq_r;
  assign transfer_ready_flag = rdy_r;

  ////////////////////////////////////////////////////////////////
  // Data and address pins ride a pipe as deep as the synchroniser.
  // The strobes reach the logic two cycles late; without this pipe the
  // latch would catch whatever the host put on the bus after releasing
  // its write strobe. Data need only stand while the write is low.
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      low_p1_r <= `HPP_PIPE_RST;
      low_p2_r <= `HPP_PIPE_RST;
      high_p1_r <= `HPP_PIPE_RST;
      high_p2_r <= `HPP_PIPE_RST;
      mode_pipe_r <= {2{`HPP_MODE_COMM}};
      tsel_pipe_r <= {2{`HPP_TYPE_DATA}};
    end else if (clk_en) begin
      low_p1_r <= host_data_low_in;
      low_p2_r <= low_p1_r;
      high_p1_r <= host_data_high_in;
      high_p2_r <= high_p1_r;
      mode_pipe_r <= {mode_pipe_r[0], port_mode_sel};
      tsel_pipe_r <= {tsel_pipe_r[0], transfer_type_sel};
    end
  end

  ////////////////////////////////////////////////////////////////
  // Edge history, read data selection and write data latch
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      rd_d_r <= 1'h0;
      wr_d_r <= 1'h0;
      out_low_r <= `HPP_STATUS_RST;
      out_high_r <= 8'h00;
      lat_low_r <= `HPP_CTRL_RST;
      lat_high_r <= 8'h00;
      lat_kind_r <= `HPP_KIND_DATA;
    end else if (clk_en) begin
      rd_d_r <= rd_s;
      wr_d_r <= wr_s;
      // Keep read data fresh until the read actually begins
      if (!rd_s) begin
        if (kind_of(port_mode_sel, transfer_type_sel) == `HPP_KIND_AUX)
          out_low_r <= dev_status;
        else
          out_low_r <= dev_rd_data;
        out_high_r <= dev_rd_data_high;
      end
      // Sample delayed pins while write is low; last sample is the edge value
      if (wr_s) begin
        lat_low_r <= low_p2_r;
        lat_high_r <= high_p2_r;
        lat_kind_r <= kind_of(mode_dly, tsel_dly);
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Hand write to the device at the write rising edge
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      dev_wr_data <= 8'h00;
      dev_wr_data_high <= 8'h00;
      dev_wr_kind <= `HPP_KIND_DATA;
      dev_wr_strobe <= 1'h0;
    end else if (clk_en) begin
      dev_wr_strobe <= wr_end;
      if (wr_end) begin
        dev_wr_data <= lat_low_r;
        dev_wr_data_high <= (lat_kind_r == `HPP_KIND_FAST) ? lat_high_r : 8'h00;
        dev_wr_kind <= lat_kind_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Request line and ready flag; a new event wins over the clear.
  // The word that a read is just handing over no longer counts as waiting:
  // the device side drops its valid one edge after the taken pulse, so
  // the request must not be raised again in that cycle.
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      irq_r <= 1'h0;
      rdy_r <= 1'h1;
    end else if (clk_en) begin
      if (port_mode_sel == `HPP_MODE_COMM && dev_rd_valid && !rd_s && !rd_end)
        irq_r <= 1'h1;
      else if (rd_start || port_mode_sel == `HPP_MODE_FAST)
        irq_r <= 1'h0;
      // Ready drops as a fast access starts, returns on device done
      if (dev_fast_done)
        rdy_r <= 1'h1;
      else if (port_mode_sel == `HPP_MODE_FAST && (rd_start || wr_start))
        rdy_r <= 1'h0;
    end
  end
endmodule // hpp_port

// ===== hpp_host_model.sv
// Host side model: strobes, address pins and write data
`timescale 1ns/1ps
module hpp_host_model (
  input wire sys_clk,
  input wire transfer_ready_flag,
  input wire host_data_low_oe,
  input wire host_data_high_oe,
  input wire [7:0] host_data_low_out,
  input wire [7:0] host_data_high_out,
  output reg host_select_n = 1'h1,
  output reg host_read_n = 1'h1,
  output reg host_write_n = 1'h1,
  output reg transfer_type_sel = 1'h0,
  output reg port_mode_sel = 1'h0,
  output wire [7:0] host_data_low_in,
  output wire [7:0] host_data_high_in
);
  reg [15:0] bus_r = 16'h0000;
  // Wire level: the port wins while it drives, else what the host left
  assign host_data_low_in = host_data_low_oe ? host_data_low_out : bus_r[7:0];
  assign host_data_high_in = host_data_high_oe ? host_data_high_out : bus_r[15:8];
  // Strobe held 6 cycles: the port only sees it through two flops
  task acc(input s, input w, input m, input t, input [15:0] d, output [15:0] q);
    begin
      while (m && !transfer_ready_flag) @(negedge sys_clk);
      {host_select_n, port_mode_sel, transfer_type_sel, bus_r} = {!s, m, t, d};
      @(negedge sys_clk);
      if (w) host_write_n = 1'h0;
      else host_read_n = 1'h0;
      repeat (6) @(negedge sys_clk);
      q = {host_data_high_in, host_data_low_in};
      {host_read_n, host_write_n} = 2'h3;
      @(negedge sys_clk);
      {host_select_n, bus_r} = {1'h1, ~bus_r};
      repeat (3) @(negedge sys_clk);
    end
  endtask
endmodule // hpp_host_model

// ===== hpp_port_chk.sv
// Pin level assertions for the host port
`timescale 1ns/1ps
module hpp_chk (
  input wire sys_clk,
  input wire sys_rst,
  input wire host_select_n,
  input wire host_read_n,
  input wire host_write_n,
  input wire port_mode_sel,
  input wire host_data_low_oe,
  input wire host_data_high_oe,
  input wire host_data_irq,
  input wire transfer_ready_flag,
  input wire dev_rd_valid,
  input wire dev_fast_done,
  input wire dev_wr_strobe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  AST_OE_LOW: assert property (host_data_low_oe == (!host_select_n && !host_read_n))
    else $error("low lane enable wrong");
  AST_OE_HIGH: assert property (host_data_high_oe |-> port_mode_sel && host_data_low_oe)
    else $error("high lane enable wrong");
  AST_WR_LAT: assert property ($rose(host_write_n) && !host_select_n |-> ##[3:4] dev_wr_strobe)
    else $error("write not taken");
  AST_STB_ONE: assert property (dev_wr_strobe |=> !dev_wr_strobe)
    else $error("write strobe too long");
  AST_DESEL: assert property (host_select_n [*8] |-> !dev_wr_strobe)
    else $error("write while deselected");
  AST_IRQ_CLR: assert property ((!host_select_n && !host_read_n) [*6] |-> !host_data_irq)
    else $error("request not cleared");
  AST_IRQ_SET: assert property ((!port_mode_sel && dev_rd_valid && host_read_n) [*6] |-> host_data_irq)
    else $error("request missing");
  AST_RDY: assert property (dev_fast_done |=> transfer_ready_flag)
    else $error("ready not set");
  C_WR: cover property (dev_wr_strobe);
  C_IRQ: cover property ($fell(host_data_irq));
  C_RDY: cover property ($rose(transfer_ready_flag));
endmodule // hpp_chk
bind hpp_port hpp_chk u_hpp_chk (.*);

// ===== tb_top.sv
// Self-checking bench for the host parallel port
`timescale 1ns/1ps
module tb_top;
  reg sys_clk = 1'h0;
  reg sys_rst = 1'h1;
  reg [7:0] dev_rd_data = 8'h5A;
  reg [7:0] dev_rd_data_high = 8'hC3;
  reg [7:0] dev_status = 8'h96;
  reg dev_rd_valid = 1'h0;
  reg dev_fast_done = 1'h0;
  reg rd_push = 1'h0;
  wire clk_en = 1'h1;
  wire host_select_n, host_read_n, host_write_n, transfer_type_sel, port_mode_sel;
  wire host_data_low_oe, host_data_high_oe, host_data_irq, transfer_ready_flag;
  wire dev_rd_taken, dev_wr_strobe;
  wire [7:0] host_data_low_in, host_data_low_out, host_data_high_in, host_data_high_out;
  wire [7:0] dev_wr_data, dev_wr_data_high;
  wire [1:0] dev_wr_kind;
  reg [15:0] q;
  reg [17:0] got;
  integer err_total = 0, compares = 0, cyc = 0, nstb = 0, k;
  hpp_port u_hpp_port (.*);
  hpp_host_model u_hpp_host_model (.*);
  always #5 sys_clk = ~sys_clk;
  // Hang guard, a run needs well under 1000 cycles
  always @(posedge sys_clk) if (++cyc > 2000) begin err_total++; end_sim; end
  // Record each write handed to the device side
  always @(posedge sys_clk) if (dev_wr_strobe === 1'h1) begin
    got = {dev_wr_kind, dev_wr_data_high, dev_wr_data};
    nstb++;
  end
  // Device side word source: one process owns the valid level
  always @(posedge sys_clk) begin
    if (dev_rd_taken) dev_rd_valid <= 1'h0;
    else if (rd_push) dev_rd_valid <= 1'h1;
  end
  task chk(input [17:0] s, input [17:0] e, input [31:0] w);
    begin
      compares++;
      if (s !== e) begin err_total++; $display("wrong value %s exp %h seen %h", w, e, s); end
    end
  endtask
  task t_write;
    begin
      for (k = 0; k < 3; k++) begin
        u_hpp_host_model.acc(1, 1, k == 2, k != 0, 16'h3C81 + k, q);
        chk(got, {k[1:0], k == 2 ? 8'h3C : 8'h00, 8'h81 + k[7:0]}, "wr");
      end
      chk(transfer_ready_flag, 18'h0, "rdy");
      dev_fast_done = 1'h1;
      @(negedge sys_clk) dev_fast_done = 1'h0;
      @(negedge sys_clk) chk(transfer_ready_flag, 18'h1, "rdy");
      u_hpp_host_model.acc(0, 1, 0, 0, 16'h0077, q);
      chk(nstb[17:0], 18'h3, "cnt");
      $display("write test done");
    end
  endtask
  task t_read;
    begin
      rd_push = 1'h1;
      @(negedge sys_clk) rd_push = 1'h0;
      repeat (7) @(negedge sys_clk);
      chk(host_data_irq, 18'h1, "irq");
      u_hpp_host_model.acc(1, 0, 0, 0, 16'h0000, q);
      chk(q[7:0], dev_rd_data, "rd");
      chk(host_data_irq, 18'h0, "irq");
      chk(dev_rd_valid, 18'h0, "tkn");
      u_hpp_host_model.acc(1, 0, 0, 1, 16'h0000, q);
      chk(q[7:0], dev_status, "st");
      u_hpp_host_model.acc(1, 0, 1, 1, 16'h0000, q);
      chk(q, {dev_rd_data_high, dev_rd_data}, "fast");
      chk(host_data_low_oe, 18'h0, "oe");
      $display("read test done");
    end
  endtask
  task end_sim;
    begin
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial begin
    repeat (10) @(negedge sys_clk);
    sys_rst = 1'h0;
    repeat (3) @(negedge sys_clk);
    t_write;
    t_read;
    end_sim;
  end
endmodule // tb_top
